// [hw/wdt_defs.svh]
// Purpose: Offsets, fields, reset values and timing of the watchdog
// Assumes: APB byte addressing, one 32-bit word per register
// Notes: Definitions only
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH
`define WDT_IDX_UNITS 8'h52
`define WDT_IDX_VALUE 8'h53
`define WDT_IDX_CFG 8'h54
`define WDT_IDX_CTRL 8'h55
`define WDT_IDX_IRQ_STAT 8'h60
`define WDT_IDX_IRQ_MASK 8'h61
`define WDT_ADDR_W 12
`define WDT_UNITS_BIT 7
`define WDT_CONF_GAME_BIT 0
`define WDT_CONF_KBD_BIT 1
`define WDT_CONF_MOUSE_BIT 2
`define WDT_CONF_MAP_HI 7
`define WDT_CONF_MAP_LO 4
`define WDT_CONF_WMASK 8'hF7
`define WDT_CSR_STAT_BIT 0
`define WDT_CSR_FORCE_BIT 2
`define WDT_CSR_LINE_BIT 3
`define WDT_CSR_RMASK 8'h09
`define WDT_RESET_BYTE 8'h00
`define WDT_MAP_INVALID 4'h2
`define WDT_MAP_OFF 4'h0
`define WDT_CLK_HZ 200000000
`define WDT_SEC_PER_MIN 60
`define WDT_CYC_PER_SEC (`WDT_CLK_HZ / 1)
`endif

// [hw/wdt_pkg.sv]
// Purpose: Types shared by the watchdog files
// Assumes: Used with wdt_defs.svh
// Notes: Types only
package wdt_pkg;
   typedef struct packed {
      logic game_access;
      logic kbd_irq;
      logic mouse_irq;
   } wdt_restart_t;
   typedef struct packed {
      logic [3:0] route;
      logic fired;
   } wdt_irq_route_t;
   typedef enum logic [1:0] {
      WDT_ST_IDLE,
      WDT_ST_RUN,
      WDT_ST_EXPIRED
   } wdt_state_t;
endpackage

// [hw/wdt_tick_gen.sv]
// Purpose: Second and minute tick enables from the system clock
// Assumes: One clock; restart aligns the prescaler
// Notes: Ticks are one-cycle pulses
`timescale 1ns/1ps
module wdt_tick_gen #(
   parameter int unsigned CYC_PER_SEC = 200000000,
   parameter int unsigned SEC_PER_MIN = 60
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Control
   input wire logic restart,
   input wire logic use_seconds,
   // Tick
   output logic unit_tick
);
   localparam int CW = $clog2(CYC_PER_SEC + 1);
   localparam int MW = $clog2(SEC_PER_MIN + 1);
   logic [CW-1:0] cyc_reg;
   logic [MW-1:0] sec_reg;
   logic sec_tick;

   // Refuse dividers that the prescalers cannot serve
   if (CYC_PER_SEC < 2 || SEC_PER_MIN < 1) begin : g_bad_param
      $error("wdt_tick_gen: bad divider parameters");
   end

   // ==================================================
   // Second prescaler
   assign sec_tick = (cyc_reg == CW'(CYC_PER_SEC - 1));
   always_ff @(posedge clk) begin
      if (srst || restart || sec_tick) begin
         cyc_reg <= '0;
      end else begin
         cyc_reg <= cyc_reg + CW'(1);
      end
   end

   // ==================================================
   // Minute prescaler
   always_ff @(posedge clk) begin
      if (srst || restart) begin
         sec_reg <= '0;
      end else if (sec_tick) begin
         if (sec_reg == MW'(SEC_PER_MIN - 1)) begin
            sec_reg <= '0;
         end else begin
            sec_reg <= sec_reg + MW'(1);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst || restart) begin
         unit_tick <= 1'b0;
      end else begin
         unit_tick <= sec_tick &&
            (use_seconds || sec_reg == MW'(SEC_PER_MIN - 1));
      end
   end
endmodule

// [hw/wdt_top.sv]
// Purpose: Watchdog timer with APB register access
// Assumes: Event inputs synchronous to clk, one-cycle or level
// Notes: Keyboard force line is edge detected
`timescale 1ns/1ps
`include "wdt_defs.svh"
module wdt_top #(
   parameter int unsigned CYC_PER_SEC = `WDT_CYC_PER_SEC,
   parameter int unsigned SEC_PER_MIN = `WDT_SEC_PER_MIN
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`WDT_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Restart and force events
   input wire wdt_pkg::wdt_restart_t restart_evt,
   input wire logic keyboard_controller_force_line,
   // Interrupts
   output wdt_pkg::wdt_irq_route_t irq_route,
   output logic irq
);
   import wdt_pkg::*;

   logic [7:0] units_select_register;
   logic [7:0] timeout_value_register;
   logic [7:0] configuration_register;
   logic [7:0] control_status_register;
   logic [1:0] irq_stat_reg;
   logic [1:0] irq_mask_reg;
   logic [7:0] count_reg;
   logic line_prev_reg;
   wdt_state_t state_reg;
   logic wr_en;
   logic rd_en;
   logic mapped;
   logic restart;
   logic line_edge;
   logic force_evt;
   logic expire;
   logic timeout_evt;
   logic status_clr;
   logic unit_tick;
   logic [7:0] wbyte;

   // Refuse dividers that the tick logic cannot serve
   if (CYC_PER_SEC < 2 || SEC_PER_MIN < 1) begin : g_bad_param
      $error("wdt_top: bad divider parameters");
   end

   // Word index from byte address
   function automatic logic [7:0] word_idx(input logic [`WDT_ADDR_W-1:0] a);
      word_idx = a[9:2];
   endfunction

   function automatic logic hit(input logic [`WDT_ADDR_W-1:0] a,
                                input logic [7:0] idx);
      hit = (a[1:0] == 2'h0) && (a[`WDT_ADDR_W-1:10] == 2'h0) &&
            (word_idx(a) == idx);
   endfunction

   // ==================================================
   // APB decode
   assign wr_en = psel && penable && pwrite && pready;
   assign rd_en = psel && penable && !pwrite && pready;
   assign wbyte = pwdata[7:0];
   assign mapped = hit(paddr, `WDT_IDX_UNITS) ||
      hit(paddr, `WDT_IDX_VALUE) || hit(paddr, `WDT_IDX_CFG) ||
      hit(paddr, `WDT_IDX_CTRL) || hit(paddr, `WDT_IDX_IRQ_STAT) ||
      hit(paddr, `WDT_IDX_IRQ_MASK);

   always_ff @(posedge clk) begin
      if (srst) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && !penable;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= psel && !penable && !mapped;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= 32'h0000_0000;
         if (hit(paddr, `WDT_IDX_UNITS)) begin
            prdata[7:0] <= units_select_register;
         end else if (hit(paddr, `WDT_IDX_VALUE)) begin
            prdata[7:0] <= timeout_value_register;
         end else if (hit(paddr, `WDT_IDX_CFG)) begin
            prdata[7:0] <= configuration_register;
         end else if (hit(paddr, `WDT_IDX_CTRL)) begin
            prdata[7:0] <= control_status_register & `WDT_CSR_RMASK;
         end else if (hit(paddr, `WDT_IDX_IRQ_STAT)) begin
            prdata[1:0] <= irq_stat_reg;
         end else if (hit(paddr, `WDT_IDX_IRQ_MASK)) begin
            prdata[1:0] <= irq_mask_reg;
         end
      end
   end

   // ==================================================
   // Registers
   always_ff @(posedge clk) begin
      if (srst) begin
         units_select_register <= `WDT_RESET_BYTE;
      end else if (wr_en && pstrb[0] && hit(paddr, `WDT_IDX_UNITS)) begin
         units_select_register <= `WDT_RESET_BYTE;
         units_select_register[`WDT_UNITS_BIT] <= wbyte[`WDT_UNITS_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         timeout_value_register <= `WDT_RESET_BYTE;
      end else if (wr_en && pstrb[0] && hit(paddr, `WDT_IDX_VALUE)) begin
         timeout_value_register <= wbyte;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         configuration_register <= `WDT_RESET_BYTE;
      end else if (wr_en && pstrb[0] && hit(paddr, `WDT_IDX_CFG)) begin
         configuration_register <= wbyte & `WDT_CONF_WMASK;
      end
   end

   // Force bit is a pulse, never stored; upper bits kept zero
   assign force_evt = (wr_en && pstrb[0] && hit(paddr, `WDT_IDX_CTRL) &&
      wbyte[`WDT_CSR_FORCE_BIT]) || line_edge;
   assign status_clr = wr_en && pstrb[0] && hit(paddr, `WDT_IDX_CTRL) &&
      !wbyte[`WDT_CSR_STAT_BIT];
   assign timeout_evt = expire || force_evt;

   always_ff @(posedge clk) begin
      if (srst) begin
         control_status_register <= `WDT_RESET_BYTE;
      end else begin
         if (wr_en && pstrb[0] && hit(paddr, `WDT_IDX_CTRL)) begin
            control_status_register[`WDT_CSR_LINE_BIT] <=
               wbyte[`WDT_CSR_LINE_BIT];
         end
         // Set wins over clear
         if (timeout_evt) begin
            control_status_register[`WDT_CSR_STAT_BIT] <= 1'b1;
         end else if (status_clr) begin
            control_status_register[`WDT_CSR_STAT_BIT] <= 1'b0;
         end else if (wr_en && pstrb[0] && hit(paddr, `WDT_IDX_CTRL)) begin
            control_status_register[`WDT_CSR_STAT_BIT] <= 1'b1;
         end
      end
   end

   // ==================================================
   // Keyboard line edge detector
   always_ff @(posedge clk) begin
      if (srst) begin
         line_prev_reg <= 1'b0;
      end else begin
         line_prev_reg <= keyboard_controller_force_line;
      end
   end
   assign line_edge = keyboard_controller_force_line && !line_prev_reg &&
      control_status_register[`WDT_CSR_LINE_BIT];

   // ==================================================
   // Restart sources
   assign restart =
      (restart_evt.game_access &&
       configuration_register[`WDT_CONF_GAME_BIT]) ||
      (restart_evt.kbd_irq &&
       configuration_register[`WDT_CONF_KBD_BIT]) ||
      (restart_evt.mouse_irq &&
       configuration_register[`WDT_CONF_MOUSE_BIT]) ||
      (wr_en && pstrb[0] && hit(paddr, `WDT_IDX_VALUE));

   wdt_tick_gen #(
      .CYC_PER_SEC(CYC_PER_SEC),
      .SEC_PER_MIN(SEC_PER_MIN)
   ) u_tick (
      .clk(clk),
      .srst(srst),
      .restart(restart),
      .use_seconds(units_select_register[`WDT_UNITS_BIT]),
      .unit_tick(unit_tick)
   );

   // ==================================================
   // Down counter
   assign expire = (state_reg == WDT_ST_RUN) && unit_tick &&
      (count_reg == 8'h01);

   always_ff @(posedge clk) begin
      if (srst) begin
         count_reg <= 8'h00;
      end else if (restart) begin
         count_reg <= (wr_en && pstrb[0] && hit(paddr, `WDT_IDX_VALUE)) ?
            wbyte : timeout_value_register;
      end else if (state_reg == WDT_ST_RUN && unit_tick) begin
         count_reg <= count_reg - 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_reg <= WDT_ST_IDLE;
      end else begin
         case (state_reg)
            WDT_ST_IDLE: begin
               if (restart && count_next_nonzero()) begin
                  state_reg <= WDT_ST_RUN;
               end
            end
            WDT_ST_RUN: begin
               if (restart && !count_next_nonzero()) begin
                  state_reg <= WDT_ST_IDLE;
               end else if (expire) begin
                  state_reg <= WDT_ST_EXPIRED;
               end
            end
            WDT_ST_EXPIRED: begin
               if (restart && count_next_nonzero()) begin
                  state_reg <= WDT_ST_RUN;
               end
            end
            default: state_reg <= WDT_ST_IDLE;
         endcase
      end
   end

   function automatic logic count_next_nonzero();
      count_next_nonzero = (wr_en && pstrb[0] &&
         hit(paddr, `WDT_IDX_VALUE)) ?
         (wbyte != 8'h00) : (timeout_value_register != 8'h00);
   endfunction

   // ==================================================
   // Interrupt routing and local interrupt
   always_ff @(posedge clk) begin
      if (srst) begin
         irq_route <= '0;
      end else begin
         irq_route.route <= configuration_register[`WDT_CONF_MAP_HI:
                                                   `WDT_CONF_MAP_LO];
         irq_route.fired <= (timeout_evt ||
            (control_status_register[`WDT_CSR_STAT_BIT] && !status_clr)) &&
            configuration_register[`WDT_CONF_MAP_HI:`WDT_CONF_MAP_LO] !=
               `WDT_MAP_OFF &&
            configuration_register[`WDT_CONF_MAP_HI:`WDT_CONF_MAP_LO] !=
               `WDT_MAP_INVALID;
      end
   end

   // Bit 0 timeout, bit 1 restart; read clears, set wins
   always_ff @(posedge clk) begin
      if (srst) begin
         irq_stat_reg <= 2'h0;
      end else begin
         if (rd_en && hit(paddr, `WDT_IDX_IRQ_STAT)) begin
            irq_stat_reg <= {restart, timeout_evt};
         end else begin
            irq_stat_reg <= irq_stat_reg | {restart, timeout_evt};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         irq_mask_reg <= 2'h0;
      end else if (wr_en && pstrb[0] && hit(paddr, `WDT_IDX_IRQ_MASK)) begin
         irq_mask_reg <= wbyte[1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         irq <= 1'b0;
      end else begin
         irq <= |((irq_stat_reg | {restart, timeout_evt}) & irq_mask_reg &
            ~{2{rd_en && hit(paddr, `WDT_IDX_IRQ_STAT)}}) ||
            |({restart, timeout_evt} & irq_mask_reg);
      end
   end
endmodule

// [dv/wdt_props.sv]
// Purpose: Port assertions for the watchdog
// Assumes: One clock, sync reset, APB answer after one setup cycle
// Notes: Bound to wdt_top
`timescale 1ns/1ps
`include "wdt_defs.svh"
module wdt_props #(
   parameter int unsigned CYC_PER_SEC = 10,
   parameter int unsigned SEC_PER_MIN = 3
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`WDT_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Events and interrupts
   input wire wdt_pkg::wdt_restart_t restart_evt,
   input wire logic keyboard_controller_force_line,
   input wire wdt_pkg::wdt_irq_route_t irq_route,
   input wire logic irq
);
   import wdt_pkg::*;
   wire logic acc = psel && penable && pready;
   wire logic rda = acc && !pwrite;
   wire logic wrx = acc && pwrite && pstrb[0];
   wire logic wr_ctl = wrx && paddr == 12'h154;
   wire logic wr_cfg = wrx && paddr == 12'h150;
   wire logic bad_rt = irq_route.route inside {4'h0, 4'h2};
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   // ==========================================
   // Bus timing
   ready_after_setup_a: assert property (psel && !penable |=> pready)
      else $error("no pready after setup");
   ready_in_access_a: assert property (pready |-> psel && penable)
      else $error("pready outside access");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   unmapped_read_a: assert property (rda && paddr == 12'h100
      |-> pslverr && prdata == 32'h0)
      else $error("unmapped read not refused");
   // ==========================================
   // Registers and time-out
   units_reserved_a: assert property (
      rda && paddr == 12'h148 |-> prdata[6:0] == 7'h00)
      else $error("units reserved bits set");
   force_reads_zero_a: assert property (
      rda && paddr == 12'h154 |-> prdata[7:4] == 4'h0 && !prdata[2])
      else $error("control read shows force or high bits");
   route_follows_a: assert property (
      wr_cfg |=> ##1 irq_route.route == $past(pwdata[7:4], 2))
      else $error("route differs from written nibble");
   route_off_a: assert property (
      bad_rt ##1 bad_rt |-> !irq_route.fired)
      else $error("fired on disabled route");
   force_fires_a: assert property (
      wr_ctl && pwdata[2] && !bad_rt |-> ##[1:3] irq_route.fired)
      else $error("forced time-out not seen");
   fired_sticky_a: assert property (
      irq_route.fired && !wr_ctl && !$past(wr_ctl) && !wr_cfg
      && !$past(wr_cfg) |=> irq_route.fired)
      else $error("fired dropped without clear");
   reset_quiet_a: assert property (disable iff (1'b0)
      $fell(srst) |-> !irq && !irq_route.fired && !pready)
      else $error("outputs active after reset");
endmodule
bind wdt_top wdt_props #(.CYC_PER_SEC(CYC_PER_SEC),
   .SEC_PER_MIN(SEC_PER_MIN)) u_wdt_props (.clk(clk), .srst(srst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .restart_evt(restart_evt),
   .keyboard_controller_force_line(keyboard_controller_force_line),
   .irq_route(irq_route), .irq(irq));

// [dv/wdt_top_tb.sv]
// Purpose: Self-checking bench for the watchdog
// Assumes: 10 cycles a second, 3 seconds a minute
// Notes: No random stimulus
`timescale 1ns/1ps
`include "wdt_defs.svh"
module wdt_top_tb;
   import wdt_pkg::*;
   localparam int CPS = 10;
   localparam int SPM = 3;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, kline = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'hF;
   logic pready, pslverr, irq, err;
   wdt_restart_t revt = '0;
   wdt_irq_route_t rt;
   int fail_count = 0, tests_run = 0, cyc = 0;
   always #2.5 clk = ~clk;
   wdt_top #(.CYC_PER_SEC(CPS), .SEC_PER_MIN(SPM)) u_wdt_top (
      .clk(clk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .restart_evt(revt), .keyboard_controller_force_line(kline),
      .irq_route(rt), .irq(irq));
   // ==========================================
   // Helpers
   task automatic end_sim;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count = fail_count + 1;
         end_sim();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task automatic clr;
      xfer(1'b1, 12'h154, 32'h00);
   endtask
   task automatic fire(input int lo, input int hi);
      repeat (lo) @(posedge clk);
      chk(32'(rt.fired), 32'h0);
      repeat (hi - lo) @(posedge clk);
      chk(32'(rt.fired), 32'h1);
   endtask
   // ==========================================
   // Scenarios
   task automatic t_regs;
      rchk(12'h148, 32'h0);
      rchk(12'h14C, 32'h0);
      rchk(12'h150, 32'h0);
      rchk(12'h154, 32'h0);
      pstrb <= 4'hE;
      xfer(1'b1, 12'h14C, 32'h55);
      pstrb <= 4'hF;
      rchk(12'h14C, 32'h0);
      xfer(1'b0, 12'h100, 32'h0);
      chk(32'(err), 32'h1);
      xfer(1'b1, 12'h148, 32'hFF);
      rchk(12'h148, 32'h80);
      xfer(1'b1, 12'h150, 32'hFF);
      rchk(12'h150, 32'hF7);
      xfer(1'b1, 12'h154, 32'h0C);
      rchk(12'h154, 32'h09);
      clr;
      rchk(12'h154, 32'h00);
      $display("t_regs done");
   endtask
   task automatic t_count;
      xfer(1'b1, 12'h150, 32'h10);
      xfer(1'b1, 12'h14C, 32'h02);
      fire(2 * CPS - 2, 2 * CPS + 4);
      clr;
      xfer(1'b1, 12'h148, 32'h00);
      xfer(1'b1, 12'h14C, 32'h01);
      fire(SPM * CPS - 2, SPM * CPS + 4);
      clr;
      xfer(1'b1, 12'h148, 32'h80);
      xfer(1'b1, 12'h14C, 32'hFF);
      fire(255 * CPS - 2, 255 * CPS + 4);
      clr;
      xfer(1'b1, 12'h14C, 32'h00);
      repeat (100) @(posedge clk);
      chk(32'(rt.fired), 32'h0);
      $display("t_count done");
   endtask
   task automatic t_restart;
      for (int i = 0; i < 6; i++) begin
         xfer(1'b1, 12'h150, i < 3 ? 32'h10 | (32'h1 << i) : 32'h10);
         xfer(1'b1, 12'h14C, 32'h02);
         repeat (12) @(posedge clk);
         revt <= wdt_restart_t'(3'h4 >> (i % 3));
         @(posedge clk);
         revt <= '0;
         fire(i < 3 ? 18 : 4, i < 3 ? 24 : 11);
         clr;
      end
      $display("t_restart done");
   endtask
   task automatic t_route;
      xfer(1'b1, 12'h14C, 32'hFF);
      for (int r = 0; r < 16; r++) begin
         xfer(1'b1, 12'h150, 32'(r) << 4);
         xfer(1'b1, 12'h154, 32'h04);
         repeat (3) @(posedge clk);
         chk(32'(rt.route), 32'(r));
         chk(32'(rt.fired), 32'(r != 0 && r != 2));
         clr;
      end
      $display("t_route done");
   endtask
   task automatic t_keyline;
      xfer(1'b1, 12'h150, 32'h10);
      kline <= 1'b1;
      repeat (6) @(posedge clk);
      chk(32'(rt.fired), 32'h0);
      kline <= 1'b0;
      xfer(1'b1, 12'h154, 32'h08);
      kline <= 1'b1;
      repeat (4) @(posedge clk);
      chk(32'(rt.fired), 32'h1);
      xfer(1'b1, 12'h154, 32'h08);
      repeat (6) @(posedge clk);
      chk(32'(rt.fired), 32'h0);
      kline <= 1'b0;
      clr;
      $display("t_keyline done");
   endtask
   task automatic t_irq;
      xfer(1'b0, 12'h180, 32'h0);
      xfer(1'b1, 12'h184, 32'h00);
      xfer(1'b1, 12'h154, 32'h04);
      repeat (4) @(posedge clk);
      chk(32'(irq), 32'h0);
      xfer(1'b0, 12'h180, 32'h0);
      chk(rd & 32'h1, 32'h1);
      clr;
      xfer(1'b1, 12'h184, 32'h01);
      xfer(1'b1, 12'h154, 32'h04);
      repeat (4) @(posedge clk);
      chk(32'(irq), 32'h1);
      xfer(1'b0, 12'h180, 32'h0);
      chk(32'(irq), 32'h0);
      rchk(12'h184, 32'h1);
      xfer(1'b1, 12'h14C, 32'h05);
      xfer(1'b0, 12'h180, 32'h0);
      chk(rd & 32'h2, 32'h2);
      $display("t_irq done");
   endtask
   initial begin
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      t_regs;
      t_count;
      t_restart;
      t_route;
      t_keyline;
      t_irq;
      end_sim;
   end
endmodule
